// ### shared/acsel_pkg.sv
`default_nettype none
package acsel_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [2:0] ADDR_CTRL_B  = 3'h3;
   localparam logic [2:0] ADDR_RES_LO  = 3'h4;
   localparam logic [2:0] ADDR_RES_HI  = 3'h5;
   localparam logic [2:0] ADDR_CTRL_A  = 3'h6;
   localparam logic [2:0] ADDR_SEL     = 3'h7;

   localparam logic [7:0] REG_RST      = 8'h00;
   localparam logic [7:0] RD_IDLE      = 8'h00;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int SEL_REF_HI  = 7;
   localparam int SEL_REF_LO  = 6;
   localparam int SEL_IN_HI   = 5;
   localparam int CB_BIPOLAR  = 7;
   localparam int CA_BUSY     = 6;
   localparam int CA_DONE     = 4;
   localparam int RES_HI_BITS = 2;

   // ----------------------------------------
   // reference and input codes
   // ----------------------------------------
   typedef enum logic [1:0] {
      REF_VCC  = 2'b00,
      REF_EXT  = 2'b01,
      REF_INT  = 2'b10,
      REF_RSVD = 2'b11
   } acsel_ref_t;

   localparam logic [5:0] SEL_SE_MAX  = 6'h07;
   localparam logic [5:0] SEL_GND     = 6'h20;
   localparam logic [5:0] SEL_IREF    = 6'h21;
   localparam logic [5:0] SEL_TEMP    = 6'h22;
   localparam logic [5:0] SEL_CAL0    = 6'h23;
   localparam logic [5:0] SEL_CAL3    = 6'h24;
   localparam logic [5:0] SEL_CAL7    = 6'h26;
   localparam logic [5:0] SEL_CAL_HI  = 6'h27;
   localparam logic [3:0] PAIR_BASE   = 4'h4;

   // analog source indices: 0..7 are pins
   localparam logic [3:0] SRC_TEMP = 4'h8;
   localparam logic [3:0] SRC_GND  = 4'h9;
   localparam logic [3:0] SRC_IREF = 4'ha;

   // ----------------------------------------
   // result formats
   // ----------------------------------------
   typedef logic signed [11:0] acsel_raw_t;
   localparam acsel_raw_t UNI_MIN  = 12'sh000;
   localparam acsel_raw_t UNI_MAX  = 12'sh3ff;
   localparam acsel_raw_t BIP_MAX  = 12'sh1ff;
   localparam acsel_raw_t BIP_MIN  = 12'she00;

   typedef struct packed {
      logic [3:0] pos;
      logic [3:0] neg;
      logic       diff;
      logic       gain;
      logic       cal;
      logic       temp;
   } acsel_route_t;

endpackage
`default_nettype wire

// ### shared/acsel_fmt_if.sv
`timescale 1ns/100ps
`default_nettype none
interface acsel_fmt_if;
   import acsel_pkg::*;
   logic       load;
   logic       bipolar;
   acsel_raw_t raw;
   logic [9:0] result;

   modport ctrl (output load, output bipolar, output raw, input result);
   modport fmt  (input load, input bipolar, input raw, output result);
endinterface
`default_nettype wire

// ### hdl/acsel_fmt.sv
`timescale 1ns/100ps
`default_nettype none
module acsel_fmt
   import acsel_pkg::*;
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_b,
   // result path
   acsel_fmt_if.fmt  fb
);

   typedef struct packed {
      logic [9:0] result;
   } acsel_fst_t;

   acsel_fst_t s_q;
   acsel_fst_t s_d;
   acsel_raw_t sat;

   // ----------------------------------------
   // clamp and format
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      sat = fb.raw;
      if (fb.bipolar) begin
         if (fb.raw > BIP_MAX) sat = BIP_MAX;
         if (fb.raw < BIP_MIN) sat = BIP_MIN;
      end else begin
         if (fb.raw < UNI_MIN) sat = UNI_MIN;
         if (fb.raw > UNI_MAX) sat = UNI_MAX;
      end
      // bipolar keeps the sign in bit 9, unipolar uses all ten bits
      if (fb.load) s_d.result = sat[9:0];
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) s_q <= '0;
      else        s_q <= s_d;
   end

   assign fb.result = s_q.result;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_uni_neg_zero: assert property (fb.load && !fb.bipolar && fb.raw < 0
      |=> fb.result == 10'h000) else $error("negative unipolar not zero");
   a_uni_top_sat: assert property (fb.load && !fb.bipolar && fb.raw > UNI_MAX
      |=> fb.result == 10'h3ff) else $error("unipolar not saturated");
   a_bip_low_sat: assert property (fb.load && fb.bipolar && fb.raw < BIP_MIN
      |=> fb.result == 10'h200) else $error("bipolar low not 0x200");
   a_bip_high_sat: assert property (fb.load && fb.bipolar && fb.raw > BIP_MAX
      |=> fb.result == 10'h1ff) else $error("bipolar high not 0x1ff");
   a_bip_sign_bit: assert property (fb.load && fb.bipolar
      |=> fb.result[9] == $past(fb.raw[11])) else $error("sign bit wrong");
   a_result_hold: assert property (!fb.load |=> $stable(fb.result))
      else $error("result moved without load");

   c_bip_negative: cover property (fb.load && fb.bipolar && fb.raw < 0);
   c_uni_clamped:  cover property (fb.load && !fb.bipolar && fb.raw < 0);

endmodule
`default_nettype wire

// ### hdl/acsel_ctrl.sv
// Summary of operation
// - unipolar differential result clamps negative difference to zero, range 0x000..0x3ff.
// - bipolar differential result is two's complement, 0x200 to 0x1ff.
// - in bipolar mode result bit 9 is the sign, one means negative.
// - reset gives unipolar mode; bipolar mode bit one selects bipolar.
// - input code 100010 routes and enables the temperature sensor.
// - reference change during a conversion applies only when it completes.
// - input change during a conversion applies only when it completes.
// - reference codes: supply, external pin, internal 1.1V, 11 reserved.
// - reference code 11 drives internal reference onto the external pin.
// - input codes 000000..000111 select single-ended inputs zero to seven.
// - codes for ground, internal reference, differential and calibration pairs.
// - lowest input bit picks gain for differential codes, zero 1x, one 20x.
// - top input bit swaps positive and negative for normal pairs.
// - calibration codes tie inputs zero, three or seven to both sides.
// - differential codes follow the pair table, e.g. 001000 is 0 vs 1.
// - done flag sets when the result register is updated.
// - unipolar result is ten bits, bipolar nine bits plus sign.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module acsel_ctrl
   import acsel_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_b,
   // register port
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // converter core
   input  wire logic       conv_busy,
   input  wire logic       conv_done,
   input  wire acsel_raw_t conv_raw,
   // reference controls
   output logic      [1:0] reference_select,
   output logic            vcc_ref_en,
   output logic            ext_ref_en,
   output logic            int_ref_en,
   output logic            ref_to_pin_en,
   // input routing
   output logic      [5:0] input_select,
   output logic      [3:0] pos_input,
   output logic      [3:0] neg_input,
   output logic            diff_mode,
   output logic            gain_select_bit,
   output logic            offset_cal,
   output logic            temp_sensor_en,
   // result and status
   output logic            bipolar_active,
   output logic      [9:0] result,
   output logic            result_sign_bit,
   output logic            conversion_done_flag
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [7:0]   sel;
      logic [7:0]   ctrl_b;
      logic         done;
      logic [7:0]   act_sel;
      acsel_route_t route;
      logic [7:0]   rdata;
   } acsel_cst_t;

   acsel_cst_t s_q;
   acsel_cst_t s_d;

   acsel_fmt_if fmt_bus ();

   // ----------------------------------------
   // input select decode
   // ----------------------------------------
   function automatic acsel_route_t decode(input logic [5:0] c);
      acsel_route_t r;
      logic [3:0]   k;
      logic [3:0]   t;
      r = '0;
      k = c[4:1] - PAIR_BASE;
      t = '0;
      if (c <= SEL_SE_MAX) begin
         r.pos = {1'b0, c[2:0]};
         r.neg = SRC_GND;
      end else if (c == SEL_GND) begin
         r.pos = SRC_GND;
         r.neg = SRC_GND;
      end else if (c == SEL_IREF) begin
         r.pos = SRC_IREF;
         r.neg = SRC_GND;
      end else if (c == SEL_TEMP) begin
         r.pos  = SRC_TEMP;
         r.neg  = SRC_GND;
         r.temp = 1'b1;
      end else if (c >= SEL_CAL0 && c <= SEL_CAL_HI) begin
         // same pin on both sides of the gain stage
         if (c < SEL_CAL3)      r.pos = 4'h0;
         else if (c < SEL_CAL7) r.pos = 4'h3;
         else                   r.pos = 4'h7;
         r.neg  = r.pos;
         r.diff = 1'b1;
         r.cal  = 1'b1;
         r.gain = c[0];
      end else begin
         case (k)
            4'h0: begin
               r.pos = 4'h0;
               r.neg = 4'h1;
            end
            4'h1: begin
               r.pos = 4'h0;
               r.neg = 4'h3;
            end
            4'h2: begin
               r.pos = 4'h1;
               r.neg = 4'h2;
            end
            4'h3: begin
               r.pos = 4'h1;
               r.neg = 4'h3;
            end
            4'h4: begin
               r.pos = 4'h2;
               r.neg = 4'h3;
            end
            4'h5: begin
               r.pos = 4'h3;
               r.neg = 4'h4;
            end
            4'h6: begin
               r.pos = 4'h3;
               r.neg = 4'h5;
            end
            4'h7: begin
               r.pos = 4'h3;
               r.neg = 4'h6;
            end
            4'h8: begin
               r.pos = 4'h3;
               r.neg = 4'h7;
            end
            4'h9: begin
               r.pos = 4'h4;
               r.neg = 4'h5;
            end
            4'ha: begin
               r.pos = 4'h5;
               r.neg = 4'h6;
            end
            4'hb: begin
               r.pos = 4'h6;
               r.neg = 4'h7;
            end
            default: begin
               r.pos = 4'h0;
               r.neg = 4'h1;
            end
         endcase
         if (c[SEL_IN_HI]) begin
            t     = r.pos;
            r.pos = r.neg;
            r.neg = t;
         end
         r.diff = 1'b1;
         r.gain = c[0];
      end
      return r;
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      // selection writes land in the shadow copy; control B writes take effect directly
      if (reg_wr) begin
         case (reg_addr)
            ADDR_SEL:    s_d.sel    = reg_wdata;
            ADDR_CTRL_B: s_d.ctrl_b = reg_wdata;
            default:     s_d.sel    = s_q.sel;
         endcase
      end

      // write one clears; a completion in the same cycle wins
      if (reg_wr && reg_addr == ADDR_CTRL_A && reg_wdata[CA_DONE]) begin
         s_d.done = 1'b0;
      end
      if (conv_done) s_d.done = 1'b1;

      // selection is frozen while a conversion runs
      if (!conv_busy || conv_done) begin
         s_d.act_sel = s_d.sel;
         s_d.route   = decode(s_d.sel[SEL_IN_HI:0]);
      end

      s_d.rdata = RD_IDLE;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_SEL:    s_d.rdata = s_q.sel;
            ADDR_CTRL_B: s_d.rdata = s_q.ctrl_b;
            ADDR_RES_LO: s_d.rdata = fmt_bus.result[7:0];
            ADDR_RES_HI: s_d.rdata = {6'h00, fmt_bus.result[9:8]};
            ADDR_CTRL_A: begin
               s_d.rdata[CA_BUSY] = conv_busy;
               s_d.rdata[CA_DONE] = s_q.done;
            end
            default:     s_d.rdata = RD_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) s_q <= '0;
      else        s_q <= s_d;
   end

   // ----------------------------------------
   // result formatting
   // ----------------------------------------
   // single-ended channels always use the one-sided form
   assign fmt_bus.load    = conv_done;
   assign fmt_bus.bipolar = s_q.ctrl_b[CB_BIPOLAR] && s_q.route.diff;
   assign fmt_bus.raw     = conv_raw;

   acsel_fmt u_fmt (
      .mclk  (mclk),
      .rst_b (rst_b),
      .fb    (fmt_bus)
   );

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_comb begin
      vcc_ref_en    = 1'b0;
      ext_ref_en    = 1'b0;
      int_ref_en    = 1'b0;
      ref_to_pin_en = 1'b0;
      case (acsel_ref_t'(s_q.act_sel[SEL_REF_HI:SEL_REF_LO]))
         REF_VCC:  vcc_ref_en = 1'b1;
         REF_EXT:  ext_ref_en = 1'b1;
         REF_INT:  int_ref_en = 1'b1;
         REF_RSVD: begin
            // hazard: fights any voltage applied on the pin
            int_ref_en    = 1'b1;
            ref_to_pin_en = 1'b1;
         end
         default:  vcc_ref_en = 1'b1;
      endcase
   end

   assign reference_select     = s_q.act_sel[SEL_REF_HI:SEL_REF_LO];
   assign input_select         = s_q.act_sel[SEL_IN_HI:0];
   assign pos_input            = s_q.route.pos;
   assign neg_input            = s_q.route.neg;
   assign diff_mode            = s_q.route.diff;
   assign gain_select_bit      = s_q.route.gain;
   assign offset_cal           = s_q.route.cal;
   assign temp_sensor_en       = s_q.route.temp;
   assign bipolar_active       = s_q.ctrl_b[CB_BIPOLAR];
   assign result               = fmt_bus.result;
   assign result_sign_bit      = fmt_bus.result[RES_HI_BITS*4+1];
   assign conversion_done_flag = s_q.done;
   assign reg_rdata            = s_q.rdata;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_done_sets: assert property (conv_done |=> conversion_done_flag)
      else $error("done flag not set");
   a_sel_frozen: assert property (conv_busy && !conv_done
      |=> $stable(s_q.act_sel)) else $error("selection changed mid conversion");
   a_ref_frozen: assert property (conv_busy && !conv_done
      |=> $stable(reference_select)) else $error("reference changed mid conversion");
   a_shadow_xfer: assert property (conv_done
      |=> s_q.act_sel == s_q.sel && conversion_done_flag)
      else $error("shadow not moved at completion");
   a_temp_route: assert property (input_select == SEL_TEMP
      |-> temp_sensor_en && pos_input == SRC_TEMP) else $error("temp not routed");
   a_ref_pin: assert property (reference_select == REF_RSVD |-> ref_to_pin_en)
      else $error("internal ref not on pin");
   a_gain_bit: assert property (diff_mode |-> gain_select_bit == input_select[0])
      else $error("gain bit wrong");
   a_se_route: assert property (input_select <= SEL_SE_MAX
      |-> pos_input == {1'b0, input_select[2:0]} && !diff_mode)
      else $error("single-ended route wrong");
   a_pair_first: assert property (input_select == 6'h08
      |-> pos_input == 4'h0 && neg_input == 4'h1) else $error("pair 0/1 wrong");
   a_pair_swap: assert property (input_select == 6'h28
      |-> pos_input == 4'h1 && neg_input == 4'h0) else $error("swap wrong");
   a_cal_same: assert property (offset_cal |-> pos_input == neg_input)
      else $error("calibration pins differ");
   // the default disable would mask the very cycle this one watches
   a_reset_uni: assert property (disable iff (1'b0) !rst_b |=> !bipolar_active)
      else $error("reset left bipolar");

   // ----------------------------------------
   // reference, routing and flag checks
   // ----------------------------------------
   a_ref_onehot: assert property ($onehot({vcc_ref_en, ext_ref_en, int_ref_en}))
      else $error("reference enables not one-hot");
   a_ref_vcc: assert property (reference_select == REF_VCC
      |-> vcc_ref_en && !ref_to_pin_en)
      else $error("supply reference wrong");
   a_ref_ext: assert property (reference_select == REF_EXT
      |-> ext_ref_en && !int_ref_en && !ref_to_pin_en)
      else $error("external reference wrong");
   a_ref_int: assert property (reference_select == REF_INT
      |-> int_ref_en && !ref_to_pin_en)
      else $error("internal reference wrong");
   a_gnd_route: assert property (input_select == SEL_GND
      |-> pos_input == SRC_GND && !diff_mode)
      else $error("ground route wrong");
   a_iref_route: assert property (input_select == SEL_IREF
      |-> pos_input == SRC_IREF && !diff_mode)
      else $error("internal reference route wrong");
   a_cal_zero: assert property (input_select == SEL_CAL0
      |-> offset_cal && gain_select_bit && pos_input == 4'h0)
      else $error("input zero calibration wrong");
   a_cal_range: assert property (offset_cal
      |-> input_select >= SEL_CAL0 && input_select <= SEL_CAL_HI)
      else $error("calibration outside its codes");
   a_temp_only: assert property (temp_sensor_en
      |-> input_select == SEL_TEMP)
      else $error("sensor enabled off its code");
   a_sel_idle_wr: assert property (reg_wr && reg_addr == ADDR_SEL && !conv_busy
      |=> input_select == $past(reg_wdata[SEL_IN_HI:0]))
      else $error("idle selection write not applied");
   a_flag_clear: assert property (reg_wr && reg_addr == ADDR_CTRL_A
      && reg_wdata[CA_DONE] && !conv_done |=> !conversion_done_flag)
      else $error("done flag not cleared");

   c_temp_sel:   cover property (temp_sensor_en && conv_done);
   c_pending:    cover property (conv_busy && reg_wr && reg_addr == ADDR_SEL);
   c_set_clear:  cover property (conv_done && reg_wr && reg_addr == ADDR_CTRL_A);

endmodule
`default_nettype wire

// ### dv/acsel_conv_model.sv
`timescale 1ns/100ps
`default_nettype none
module acsel_conv_model
   import acsel_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_b,
   // bench control
   input  wire logic       start,
   input  wire logic [7:0] lat,
   input  wire acsel_raw_t volt [0:10],
   // routing seen from the design
   input  wire logic [3:0] pos_input,
   input  wire logic [3:0] neg_input,
   input  wire logic       diff_mode,
   input  wire logic       gain_select_bit,
   // converter core
   output var logic        conv_busy,
   output var logic        conv_done,
   output var acsel_raw_t  conv_raw
);
   // ----------------------------------------
   // conversion timing and raw difference
   // ----------------------------------------
   logic [7:0] cnt;
   int         d;

   function automatic int pick(input logic [3:0] idx);
      return (idx <= 4'ha) ? int'(volt[idx]) : 0;
   endfunction

   always_comb begin
      d = (pick(pos_input) - pick(neg_input)) * ((diff_mode && gain_select_bit) ? 20 : 1);
      d = (d > 2047) ? 2047 : (d < -2048) ? -2048 : d;
   end

   always_ff @(posedge mclk) begin
      conv_done <= 1'b0;
      // raw code is only meaningful with the done pulse; toggle it otherwise
      conv_raw  <= ~conv_raw;
      if (!rst_b) begin
         conv_busy <= 1'b0;
         cnt       <= 8'h00;
         conv_raw  <= 12'sh555;
      end else if (start && !conv_busy) begin
         conv_busy <= 1'b1;
         cnt       <= lat;
      end else if (conv_busy) begin
         if (cnt == 8'h00) begin
            conv_busy <= 1'b0;
            conv_done <= 1'b1;
            conv_raw  <= acsel_raw_t'(d);
         end else begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ### dv/test_adc_input_select_and_result_format.sv
`timescale 1ns/100ps
`default_nettype none
module test_adc_input_select_and_result_format;
   import acsel_pkg::*;
   logic       mclk, rst_b, reg_wr, reg_rd, conv_busy, conv_done, start;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, lat, b;
   logic [1:0] reference_select;
   logic [5:0] input_select, code;
   logic [3:0] pos_input, neg_input;
   logic       vcc_ref_en, ext_ref_en, int_ref_en, ref_to_pin_en, diff_mode;
   logic       gain_select_bit, offset_cal, temp_sensor_en, bipolar_active;
   logic       result_sign_bit, conversion_done_flag, bip;
   logic [9:0] result;
   acsel_raw_t conv_raw;
   acsel_raw_t volt [0:10];
   logic [31:0] seed;
   int         n_errors, checks_done;

   acsel_ctrl i_acsel_ctrl (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .conv_busy(conv_busy), .conv_done(conv_done), .conv_raw(conv_raw),
      .reference_select(reference_select), .vcc_ref_en(vcc_ref_en),
      .ext_ref_en(ext_ref_en), .int_ref_en(int_ref_en), .ref_to_pin_en(ref_to_pin_en),
      .input_select(input_select), .pos_input(pos_input), .neg_input(neg_input),
      .diff_mode(diff_mode), .gain_select_bit(gain_select_bit), .offset_cal(offset_cal),
      .temp_sensor_en(temp_sensor_en), .bipolar_active(bipolar_active), .result(result),
      .result_sign_bit(result_sign_bit), .conversion_done_flag(conversion_done_flag));

   acsel_conv_model i_acsel_conv_model (.mclk(mclk), .rst_b(rst_b), .start(start),
      .lat(lat), .volt(volt), .pos_input(pos_input), .neg_input(neg_input),
      .diff_mode(diff_mode), .gain_select_bit(gain_select_bit), .conv_busy(conv_busy),
      .conv_done(conv_done), .conv_raw(conv_raw));

   // ----------------------------------------
   // expectations
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
   endfunction

   function automatic acsel_route_t exp_route(input logic [5:0] c);
      acsel_route_t r;
      logic [7:0]   pn;
      r = '0;
      r.neg = SRC_GND;
      if (c <= SEL_SE_MAX) r.pos = c[3:0];
      else if (c == SEL_GND) r.pos = SRC_GND;
      else if (c == SEL_IREF) r.pos = SRC_IREF;
      else if (c == SEL_TEMP) begin
         r.pos = SRC_TEMP;
         r.temp = 1'b1;
      end else begin
         r.diff = 1'b1;
         r.gain = c[0];
         case (c[4:1])
            4'h4: pn = 8'h01;
            4'h5: pn = 8'h03;
            4'h6: pn = 8'h12;
            4'h7: pn = 8'h13;
            4'h8: pn = 8'h23;
            4'h9: pn = 8'h34;
            4'ha: pn = 8'h35;
            4'hb: pn = 8'h36;
            4'hc: pn = 8'h37;
            4'hd: pn = 8'h45;
            4'he: pn = 8'h56;
            default: pn = 8'h67;
         endcase
         if (c >= SEL_CAL0 && c <= SEL_CAL_HI) begin
            r.cal = 1'b1;
            pn = (c < SEL_CAL3) ? 8'h00 : (c < SEL_CAL7) ? 8'h33 : 8'h77;
         end
         r.pos = (c[5] && !r.cal) ? pn[3:0] : pn[7:4];
         r.neg = (c[5] && !r.cal) ? pn[7:4] : pn[3:0];
      end
      return r;
   endfunction

   function automatic int vv(input logic [3:0] i);
      return (i <= 4'ha) ? int'(volt[i]) : 0;
   endfunction

   function automatic logic [9:0] exp_res(input acsel_route_t r, input logic bp);
      int d;
      d = (vv(r.pos) - vv(r.neg)) * ((r.diff && r.gain) ? 20 : 1);
      d = (d > 2047) ? 2047 : (d < -2048) ? -2048 : d;
      if (bp && r.diff) d = (d < -512) ? -512 : (d > 511) ? 511 : d;
      else d = (d < 0) ? 0 : (d > 1023) ? 1023 : d;
      return d[9:0];
   endfunction

   // ----------------------------------------
   // bus, converter and compare tasks
   // ----------------------------------------
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t register read %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_out(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t output %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_sel(input logic [5:0] c, input logic [1:0] rf);
      acsel_route_t e;
      e = exp_route(c);
      cmp_out(12'(pos_input), 12'(e.pos));
      cmp_out(12'(neg_input), 12'(e.neg));
      cmp_out(12'(diff_mode), 12'(e.diff));
      if (e.diff) cmp_out(12'(gain_select_bit), 12'(e.gain));
      cmp_out(12'(offset_cal), 12'(e.cal));
      cmp_out(12'(temp_sensor_en), 12'(e.temp));
      cmp_out(12'({reference_select, input_select}), 12'({rf, c}));
      cmp_out(12'({vcc_ref_en, ext_ref_en, int_ref_en, ref_to_pin_en}),
              12'({rf == 2'b00, rf == 2'b01, rf[1], rf == 2'b11}));
   endtask

   task automatic go(input logic [7:0] l);
      @(posedge mclk);
      start <= 1'b1;
      lat <= l;
      @(posedge mclk);
      start <= 1'b0;
      #1;
   endtask

   task automatic wait_done;
      int k;
      k = 0;
      while (conv_done !== 1'b1 && k < 300) begin
         @(posedge mclk);
         #1;
         k++;
      end
      if (k >= 300) cmp_out(12'h001, 12'h000);
      @(posedge mclk);
      #1;
   endtask

   task automatic wrap_up;
      if (n_errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // clock, watchdog and sequence
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   initial begin
      #3000000;
      n_errors++;
      wrap_up();
   end

   initial begin
      rst_b = 1'b0;
      {reg_addr, reg_wdata, reg_wr, reg_rd, start, lat} = '0;
      foreach (volt[j]) volt[j] = 12'sh000;
      volt[10] = 12'sh064;
      seed = 32'h00016caa; // 93354
      n_errors = 0;
      checks_done = 0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      #1;
      for (int a = 0; a < 8; a++) begin
         rd(3'(a), b);
         cmp_reg(b, REG_RST);
      end
      chk_sel(6'h00, 2'b00);
      cmp_out(12'({bipolar_active, conversion_done_flag, result}), 12'h000);
      wr(3'h1, 8'hff);
      rd(3'h1, b);
      cmp_reg(b, RD_IDLE);
      for (int i = 0; i < 64; i++) begin
         wr(ADDR_SEL, {2'(i), 6'(i)});
         chk_sel(6'(i), 2'(i));
         rd(ADDR_SEL, b);
         cmp_reg(b, {2'(i), 6'(i)});
      end
      // a selection written mid-conversion is held until completion
      wr(ADDR_SEL, {REF_VCC, 6'h09});
      repeat (13) @(posedge mclk);
      go(8'd10);
      wr(ADDR_SEL, {REF_INT, SEL_TEMP});
      chk_sel(6'h09, 2'b00);
      rd(ADDR_CTRL_A, b);
      cmp_reg(b, 8'h40);
      wait_done();
      cmp_out(12'(conversion_done_flag), 12'h001);
      chk_sel(SEL_TEMP, 2'b10);
      wr(ADDR_CTRL_A, 8'h10);
      for (int n = 0; n < 40; n++) begin
         for (int j = 0; j < 9; j++) begin
            seed = lfsr(seed);
            volt[j] = {5'h00, seed[6:0]};
         end
         seed = lfsr(seed);
         code = seed[5:0];
         bip = seed[6];
         if (n < 4) begin
            // saturation corners of both formats
            code = 6'h09;
            bip = n[1];
            volt[0] = n[0] ? 12'sh07f : 12'sh000;
            volt[1] = n[0] ? 12'sh000 : 12'sh07f;
         end
         wr(ADDR_CTRL_B, {bip, seed[14:8]});
         rd(ADDR_CTRL_B, b);
         cmp_reg(b, {bip, seed[14:8]});
         cmp_out(12'(bipolar_active), 12'(bip));
         wr(ADDR_SEL, {seed[16:15], code});
         repeat (13) @(posedge mclk);
         go({4'h0, seed[20:17]});
         wait_done();
         b = 8'(exp_res(exp_route(code), bip) >> 8);
         cmp_out(12'(result), 12'(exp_res(exp_route(code), bip)));
         cmp_out(12'(result_sign_bit), 12'(b[1]));
         cmp_out(12'(conversion_done_flag), 12'h001);
         rd(ADDR_RES_HI, b);
         cmp_reg(b, 8'(exp_res(exp_route(code), bip) >> 8));
         rd(ADDR_RES_LO, b);
         cmp_reg(b, 8'(exp_res(exp_route(code), bip)));
         wr(ADDR_CTRL_A, 8'h10);
         cmp_out(12'(conversion_done_flag), 12'h000);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
